// >>> verilog/dsac_consts.svh
// Purpose: Shared constants for the dual converter control block.
// Assumes: Peripheral clock of 25 MHz; one 16-bit register bus.
// Notes: Included by its bare name; definitions only.
// How it works
// - Two converter units, 0 and 1, each with private registers; unit 0's paired trigger selects also start unit 1.
// - Result sits in bits 15 to 6; the six low bits read zero.
// - Eight read-only 16-bit results per unit; host reads whole words only.
// - Set bit 0 maps inputs 0-7 to unit 0; set 1 maps 8-15 to unit 1.
// - Reduced variant: unit 1 stores only inputs 12 and 13, into E and F.
// - Single mode converts one input; scan repeats a group of up to 4 or 8.
// - One conversion lasts 64 or 40 conversion clock cycles.
// - Each unit divides the peripheral clock by 1, 2, 4 or 8.
// - Start by software write, pulse timer or 8-bit timer, or pin.
// - Unit 0 has pin triggers A and B, unit 1 one; select bits choose.
// - End flag, bit 7, resets to 0, set when a single conversion ends.
// - In scan mode the end flag sets only after the whole group.
// - Writing 0 after reading 1 clears the end flag; writing 1 is ignored.
// - A result read by a DMA or transfer controller clears the end flag.
// - Enable bit 6, reset 0; interrupt is flag and enable together.
// - Module stop halts the unit clock; no conversions happen.
// - Start bit self-clears after single; scan runs until cleared or auto-clear.
// - Mode field: upper bit 0 single, 10 four-input group, 11 eight-input group.
// - Low three select bits give input or group end; groups start at 0 or 4.
`ifndef DSAC_CONSTS_SVH
`define DSAC_CONSTS_SVH
`define DSAC_IDX_CSR 4'h8
`define DSAC_IDX_CR 4'h9
`define DSAC_ADDR_UNIT 4
`define DSAC_CSR_FLAG 7
`define DSAC_CSR_IE 6
`define DSAC_CSR_START 5
`define DSAC_CSR_EXCKS 4
`define DSAC_CSR_SET 3
`define DSAC_CR_TRG1 7
`define DSAC_CR_TRG0 6
`define DSAC_CR_SCAN_ENABLE_BIT 5
`define DSAC_CR_SCAN_GROUP_SIZE_BIT 4
`define DSAC_CR_CKS1 3
`define DSAC_CR_CKS0 2
`define DSAC_CR_STCLR 1
`define DSAC_CR_EXTRG 0
`define DSAC_CSR_RST 8'h00
`define DSAC_CR_RST 8'h00
`define DSAC_RES_RST 16'h0000
`define DSAC_RES_PAD 6'h00
`define DSAC_CYC_LONG 6'h3f
`define DSAC_CYC_SHORT 6'h27
`define DSAC_DIV1 3'h0
`define DSAC_DIV2 3'h1
`define DSAC_DIV4 3'h3
`define DSAC_DIV8 3'h7
`define DSAC_TRG_PT 3'h2
`define DSAC_TRG_TM 3'h4
`define DSAC_TRG_PA 3'h6
`define DSAC_TRG_PB 3'h1
`define DSAC_TRG_PT2 3'h3
`define DSAC_TRG_TM2 3'h5
`define DSAC_TRG_PB2 3'h7
`define DSAC_RED_E 3'h4
`define DSAC_RED_F 3'h5
`endif

// >>> verilog/dsac_pkg.sv
// Purpose: Types for the dual converter control block.
// Assumes: Nothing beyond the constants header.
// Notes: Types only.
package dsac_pkg;
  typedef enum logic {DSAC_IDLE, DSAC_CONV} dsac_state_e;
endpackage : dsac_pkg

// >>> verilog/dsac_top.sv
// Purpose: Control, sequencing and result storage for two converter units.
// Assumes: Analog core returns data valid when a conversion's count ends.
// Notes: Register reads answer one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
`include "dsac_consts.svh"
module dsac_top #(
  parameter bit REDUCED_U1 = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [1:0] mod_stop,
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [4:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  input wire logic [1:0] xfer_active,
  input wire logic pulse_timer_unit_trig,
  input wire logic eight_bit_timer_trig,
  input wire logic ext_trigger_u0_a,
  input wire logic ext_trigger_u0_b,
  input wire logic ext_trigger_u1,
  output logic [1:0] ana_start,
  output logic [7:0] ana_ch,
  input wire logic [19:0] ana_data,
  output logic [1:0] conversion_end_irq
);
  import dsac_pkg::*;

  function automatic logic [2:0] div_mask(input logic [1:0] cks);
    case (cks)
      2'h0: div_mask = `DSAC_DIV8;
      2'h1: div_mask = `DSAC_DIV4;
      2'h2: div_mask = `DSAC_DIV2;
      default: div_mask = `DSAC_DIV1;
    endcase
  endfunction : div_mask

  // Returns {start, also start the other unit}
  function automatic logic [1:0] trig_hit(input logic [2:0] sel,
      input logic pt, input logic tm, input logic pa, input logic pb);
    case (sel)
      `DSAC_TRG_PT: trig_hit = {pt, 1'b0};
      `DSAC_TRG_TM: trig_hit = {tm, 1'b0};
      `DSAC_TRG_PA: trig_hit = {pa, 1'b0};
      `DSAC_TRG_PB: trig_hit = {pb, 1'b0};
      `DSAC_TRG_PT2: trig_hit = {pt, pt};
      `DSAC_TRG_TM2: trig_hit = {tm, tm};
      `DSAC_TRG_PB2: trig_hit = {pb, pb};
      default: trig_hit = 2'h0;
    endcase
  endfunction : trig_hit

  logic [7:0] csr_q [2];
  logic [7:0] cr_q [2];
  logic [15:0] res_q [2][8];
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_edge;
  logic [1:0] hit0;
  logic [1:0] hit1;
  logic [1:0] trig;
  logic [15:0] rdata_q;
  logic [3:0] idx;

  assign idx = bus_addr[3:0];

  // Pins pass two flops; edge taken between second and third
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      pin_s3_q <= 3'h7;
    end else if (ce) begin
      pin_s1_q <= {ext_trigger_u1, ext_trigger_u0_b, ext_trigger_u0_a};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Falling edge starts, as the trigger pins idle high
  assign pin_edge = pin_s3_q & ~pin_s2_q;

  assign hit0 = trig_hit({cr_q[0][`DSAC_CR_TRG1], cr_q[0][`DSAC_CR_TRG0],
      cr_q[0][`DSAC_CR_EXTRG]}, pulse_timer_unit_trig, eight_bit_timer_trig,
      pin_edge[0], pin_edge[1]);
  assign hit1 = trig_hit({cr_q[1][`DSAC_CR_TRG1], cr_q[1][`DSAC_CR_TRG0],
      cr_q[1][`DSAC_CR_EXTRG]}, pulse_timer_unit_trig, eight_bit_timer_trig,
      pin_edge[2], pin_edge[2]);
  assign trig = {hit1[1] | hit0[0], hit0[1]};

  for (genvar u = 0; u < 2; u++) begin : g_unit
    dsac_state_e st_q;
    logic [2:0] cur_q;
    logic [2:0] pre_q;
    logic [5:0] cyc_q;
    logic rd1_q;
    logic fpend_q;
    logic run;
    logic tick;
    logic scan;
    logic start;
    logic done;
    logic grp_end;
    logic begin_c;
    logic [2:0] first;
    logic [2:0] last;
    logic [5:0] cyc_last;
    logic wr_u;
    logic rd_u;
    logic keep;
    logic sw_clr;
    logic dma_clr;

    assign run = ce & ~mod_stop[u];
    assign wr_u = bus_sel & bus_wr & (bus_addr[`DSAC_ADDR_UNIT] == 1'(u));
    assign rd_u = bus_sel & bus_rd & (bus_addr[`DSAC_ADDR_UNIT] == 1'(u));
    assign scan = cr_q[u][`DSAC_CR_SCAN_ENABLE_BIT];
    assign start = csr_q[u][`DSAC_CSR_START];
    assign tick = (pre_q & div_mask(cr_q[u][3:2])) == div_mask(cr_q[u][3:2]);
    assign cyc_last = csr_q[u][`DSAC_CSR_EXCKS] ? `DSAC_CYC_SHORT
                                               : `DSAC_CYC_LONG;
    assign last = csr_q[u][2:0];
    always_comb begin
      first = csr_q[u][2:0];
      if (scan) begin
        first = cr_q[u][`DSAC_CR_SCAN_GROUP_SIZE_BIT] ? 3'h0 : {csr_q[u][2], 2'h0};
      end
    end
    assign done = run & (st_q == DSAC_CONV) & start & tick & (cyc_q == cyc_last);
    assign grp_end = done & (~scan | (cur_q == last));
    assign begin_c = run & (st_q == DSAC_IDLE) & start;
    // Reduced variant keeps only E and F of unit 1
    assign keep = (csr_q[u][`DSAC_CSR_SET] == 1'(u)) &
        (u == 0 || !REDUCED_U1 || cur_q == `DSAC_RED_E
         || cur_q == `DSAC_RED_F);

    always_ff @(posedge clk) begin
      if (srst) begin
        pre_q <= 3'h0;
      end else if (run) begin
        pre_q <= pre_q + 3'h1;
      end
    end

    // Sequencer; a cleared start bit aborts at once
    always_ff @(posedge clk) begin
      if (srst) begin
        st_q <= DSAC_IDLE;
        cur_q <= 3'h0;
        cyc_q <= 6'h00;
      end else if (run) begin
        case (st_q)
          DSAC_IDLE: begin
            if (start) begin
              st_q <= DSAC_CONV;
              cur_q <= first;
              cyc_q <= 6'h00;
            end
          end
          DSAC_CONV: begin
            if (!start) begin
              st_q <= DSAC_IDLE;
            end else if (tick) begin
              if (cyc_q != cyc_last) begin
                cyc_q <= cyc_q + 6'h01;
              end else begin
                cyc_q <= 6'h00;
                if (!scan) begin
                  st_q <= DSAC_IDLE;
                end else if (cur_q == last) begin
                  cur_q <= first;
                end else begin
                  cur_q <= cur_q + 3'h1;
                end
              end
            end
          end
          default: st_q <= DSAC_IDLE;
        endcase
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        ana_start[u] <= 1'b0;
        ana_ch[u*4 +: 4] <= 4'h0;
      end else if (ce) begin
        ana_start[u] <= begin_c | (done & scan & ~(grp_end &
            cr_q[u][`DSAC_CR_STCLR]));
        if (begin_c) begin
          ana_ch[u*4 +: 4] <= {csr_q[u][`DSAC_CSR_SET], first};
        end else if (done) begin
          ana_ch[u*4 +: 4] <= {csr_q[u][`DSAC_CSR_SET],
              (cur_q == last) ? first : cur_q + 3'h1};
        end
      end
    end

    for (genvar r = 0; r < 8; r++) begin : g_res
      always_ff @(posedge clk) begin
        if (srst) begin
          res_q[u][r] <= `DSAC_RES_RST;
        end else if (ce && done && keep && cur_q == 3'(r)) begin
          res_q[u][r] <= {ana_data[u*10 +: 10], `DSAC_RES_PAD};
        end
      end
    end

    // Flag set is delayed so the start bit clears first
    always_ff @(posedge clk) begin
      if (srst) begin
        fpend_q <= 1'b0;
      end else if (ce) begin
        fpend_q <= grp_end;
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        rd1_q <= 1'b0;
      end else if (ce) begin
        if (wr_u && idx == `DSAC_IDX_CSR) begin
          rd1_q <= 1'b0;
        end else if (rd_u && idx == `DSAC_IDX_CSR && csr_q[u][`DSAC_CSR_FLAG]) begin
          rd1_q <= 1'b1;
        end
      end
    end

    assign sw_clr = wr_u & (idx == `DSAC_IDX_CSR) &
        ~bus_wdata[`DSAC_CSR_FLAG] & rd1_q;
    assign dma_clr = rd_u & ~idx[3] & xfer_active[u];

    always_ff @(posedge clk) begin
      if (srst) begin
        csr_q[u] <= `DSAC_CSR_RST;
      end else if (ce) begin
        // Set beats clear so no completion is lost
        if (fpend_q) begin
          csr_q[u][`DSAC_CSR_FLAG] <= 1'b1;
        end else if (sw_clr || dma_clr) begin
          csr_q[u][`DSAC_CSR_FLAG] <= 1'b0;
        end
        if (wr_u && idx == `DSAC_IDX_CSR) begin
          csr_q[u][6:0] <= bus_wdata[6:0];
        end else if (done && (!scan || (grp_end && cr_q[u][`DSAC_CR_STCLR]))) begin
          csr_q[u][`DSAC_CSR_START] <= 1'b0;
        end else if (trig[u] && !mod_stop[u]) begin
          csr_q[u][`DSAC_CSR_START] <= 1'b1;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        cr_q[u] <= `DSAC_CR_RST;
      end else if (ce && wr_u && idx == `DSAC_IDX_CR) begin
        cr_q[u] <= bus_wdata[7:0];
      end
    end

    assign conversion_end_irq[u] = csr_q[u][`DSAC_CSR_FLAG] &
        csr_q[u][`DSAC_CSR_IE];
  end

  // Results are read-only; writes to them are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 16'h0000;
    end else if (ce && bus_sel && bus_rd) begin
      if (!idx[3]) begin
        rdata_q <= res_q[bus_addr[`DSAC_ADDR_UNIT]][idx[2:0]];
      end else if (idx == `DSAC_IDX_CSR) begin
        rdata_q <= {8'h00, csr_q[bus_addr[`DSAC_ADDR_UNIT]]};
      end else if (idx == `DSAC_IDX_CR) begin
        rdata_q <= {8'h00, cr_q[bus_addr[`DSAC_ADDR_UNIT]]};
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

  assign bus_rdata = rdata_q;
endmodule : dsac_top
`default_nettype wire

// >>> bench/dsac_checker.sv
// Purpose: Port-level checks for the dual converter control block.
// Assumes: Clock enable held high while checks matter.
// Notes: Bound onto the top module below.
`timescale 1ns/10ps
`default_nettype none
module dsac_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [1:0] mod_stop,
  input wire logic bus_sel,
  input wire logic bus_rd,
  input wire logic [4:0] bus_addr,
  input wire logic [15:0] bus_rdata,
  input wire logic [1:0] ana_start,
  input wire logic [1:0] conversion_end_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_rd;
    ce && bus_sel && bus_rd;
  endsequence
  property p_irq_rst;
    $fell(srst) |-> conversion_end_irq == 2'h0;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
  property p_pad;
    s_rd ##0 !bus_addr[3] |=> bus_rdata[5:0] == 6'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("result low bits not zero");
  property p_unmap;
    s_rd ##0 bus_addr[3:0] > 4'h9 |=> bus_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_csr_hi;
    s_rd ##0 bus_addr[3:1] == 3'h4 |=> bus_rdata[15:8] == 8'h00;
  endproperty
  a_csr_hi: assert property (p_csr_hi) else $error("byte register upper half");
  property p_pulse0;
    ana_start[0] |=> !ana_start[0] [*2];
  endproperty
  a_pulse0: assert property (p_pulse0) else $error("unit 0 start too long");
  property p_pulse1;
    ana_start[1] |=> !ana_start[1] [*2];
  endproperty
  a_pulse1: assert property (p_pulse1) else $error("unit 1 start too long");
  property p_stop0;
    mod_stop[0] && !ana_start[0] |=> !ana_start[0];
  endproperty
  a_stop0: assert property (p_stop0) else $error("unit 0 ran while stopped");
  property p_stop1;
    mod_stop[1] && !ana_start[1] |=> !ana_start[1];
  endproperty
  a_stop1: assert property (p_stop1) else $error("unit 1 ran while stopped");
endmodule : dsac_checker
bind dsac_top dsac_checker i_dsac_checker (.clk(clk), .srst(srst), .ce(ce),
  .mod_stop(mod_stop), .bus_sel(bus_sel), .bus_rd(bus_rd), .bus_addr(bus_addr),
  .bus_rdata(bus_rdata), .ana_start(ana_start), .conversion_end_irq(conversion_end_irq));
`default_nettype wire

// >>> bench/dsac_ana_model.sv
// Purpose: Analog core stand-in giving a known value per channel.
// Assumes: Result depends only on the channel latched at start.
// Notes: Upper pattern differs per unit to expose crossed units.
`timescale 1ns/10ps
`default_nettype none
module dsac_ana_model (
  input wire logic clk,
  input wire logic [1:0] ana_start,
  input wire logic [7:0] ana_ch,
  output logic [19:0] ana_data
);
  logic [7:0] ch_q = 8'h00;
  always_ff @(posedge clk) begin
    if (ana_start[0]) ch_q[3:0] <= ana_ch[3:0];
    if (ana_start[1]) ch_q[7:4] <= ana_ch[7:4];
  end
  assign ana_data = {6'h25, ch_q[7:4], 6'h1a, ch_q[3:0]};
endmodule : dsac_ana_model
`default_nettype wire

// >>> bench/tb_dual_sar_adc_control.sv
// Purpose: Directed register-level test of the dual converter control block.
// Assumes: Clock enable held high; unit 1 pin left idle.
// Notes: Fast clock selects keep conversions short.
`timescale 1ns/10ps
`default_nettype none
module tb_dual_sar_adc_control;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] mod_stop = 2'h0;
  logic bus_sel = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [4:0] bus_addr = 5'h00;
  logic [15:0] bus_wdata = 16'h0000;
  logic [1:0] xfer_active = 2'h0;
  logic pt = 1'b0;
  logic tm = 1'b0;
  logic pa = 1'b1;
  logic pb = 1'b1;
  logic [15:0] bus_rdata;
  logic [1:0] ana_start;
  logic [7:0] ana_ch;
  logic [19:0] ana_data;
  logic [1:0] irq;
  int errors = 0;
  int n_tests = 0;
  int n, b, i, s0 = 0, s1 = 0;
  logic [7:0] ctl [3] = '{8'h0c, 8'h0c, 8'h08};
  logic [7:0] csr [3] = '{8'h73, 8'h60, 8'h77};
  int tk [3] = '{40, 64, 80};
  logic [7:0] tc [5] = '{8'h4c, 8'h8c, 8'hcc, 8'h0d, 8'h4c};
  initial forever #20 clk = ~clk;
  dsac_top i_dsac_top (.clk(clk), .srst(srst), .ce(1'b1), .mod_stop(mod_stop),
    .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .xfer_active(xfer_active),
    .pulse_timer_unit_trig(pt), .eight_bit_timer_trig(tm), .ext_trigger_u0_a(pa),
    .ext_trigger_u0_b(pb), .ext_trigger_u1(1'b1), .ana_start(ana_start), .ana_ch(ana_ch),
    .ana_data(ana_data), .conversion_end_irq(irq));
  dsac_ana_model i_dsac_ana_model (.clk(clk), .ana_start(ana_start), .ana_ch(ana_ch),
    .ana_data(ana_data));
  always @(negedge clk) begin
    s0 += int'(ana_start[0] === 1'b1);
    s1 += int'(ana_start[1] === 1'b1);
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_sel <= 1'b1;
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= {8'h00, d};
    @(posedge clk);
    bus_sel <= 1'b0;
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    bus_sel <= 1'b1;
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_sel <= 1'b0;
    bus_rd <= 1'b0;
    @(negedge clk);
    chk("read_data", e, bus_rdata);
  endtask : rd
  task automatic wirq(input int u);
    n = 0;
    while (irq[u] !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask : wirq
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: pt <= 1'b1;
      1: tm <= 1'b1;
      2: pa <= 1'b0;
      default: pb <= 1'b0;
    endcase
    @(posedge clk);
    pt <= 1'b0;
    tm <= 1'b0;
    // Pins stay low long enough to pass the synchroniser
    repeat (2) @(posedge clk);
    pa <= 1'b1;
    pb <= 1'b1;
  endtask : fire
  task automatic test_done();
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(5'h08, 16'h0000);
    rd(5'h19, 16'h0000);
    wr(5'h03, 8'hff);
    rd(5'h03, 16'h0000);
    rd(5'h0c, 16'h0000);
    for (i = 0; i < 3; i++) begin
      wr(5'h09, ctl[i]);
      wr(5'h08, csr[i]);
      wirq(0);
      chk("conv_cycles", 16'h1, 16'(n + 1 >= tk[i] && n <= tk[i] + 6));
      rd({1'b0, csr[i][3:0]}, {6'h1a, csr[i][3:0], 6'h00});
      rd(5'h08, {8'h00, csr[i] ^ 8'ha0});
      wr(5'h08, csr[i] ^ 8'ha0);
      @(negedge clk);
      chk("irq_kept", 16'h1, {15'h0, irq[0]});
      rd(5'h08, {8'h00, csr[i] ^ 8'ha0});
      wr(5'h08, 8'h40);
      @(negedge clk);
      chk("irq_clear", 16'h0, {15'h0, irq[0]});
    end
    wr(5'h19, 8'h2e);
    b = s1;
    wr(5'h18, 8'h7d);
    wirq(1);
    chk("scan_starts", 16'h2, 16'(s1 - b));
    chk("irq_other", 16'h0, {15'h0, irq[0]});
    rd(5'h14, {6'h25, 4'hc, 6'h00});
    rd(5'h15, {6'h25, 4'hd, 6'h00});
    rd(5'h18, 16'h00dd);
    @(posedge clk);
    xfer_active <= 2'h2;
    rd(5'h14, {6'h25, 4'hc, 6'h00});
    @(posedge clk);
    xfer_active <= 2'h0;
    @(negedge clk);
    chk("dma_clear", 16'h0, {15'h0, irq[1]});
    wr(5'h08, 8'h12);
    for (i = 0; i < 5; i++) begin
      if (i == 4) mod_stop <= 2'h3;
      wr(5'h09, tc[i]);
      b = s0;
      fire(i % 4);
      repeat (60) @(posedge clk);
      chk("trig_start", 16'(i < 4), 16'(s0 - b));
    end
    test_done();
  end
endmodule : tb_dual_sar_adc_control
`default_nettype wire
